// ==== sdd_decim.sv ====
// Three-channel sigma-delta decimator with phase offset and bus access.
module sdd_decim (
    input wire logic ref_clk, // Main clock, 100 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size, word only.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    output logic [31:0] hrdata, // AHB read data.
    input wire logic [2:0] mod_bits, // Modulator bits, one per channel.
    output logic modulator_clock, // Modulator clock out.
    output logic conversion_ready_n // Data ready, active low.
);
    import sdd_pkg::*;

    logic [2:0] osr_sel_ff;
    logic turbo_ff;
    logic [NCH-1:0] ch_en_ff;
    logic resync_ff;
    logic [CFG_W-1:0] cfg_ff [NCH];
    logic [NCH-1:0] restart;
    logic wr_ph_ff;
    logic [7:0] addr_ff;
    logic hready_ff;
    logic [31:0] hrdata_ff;
    logic modulator_clock_ff;
    logic [1:0] div_ff;
    logic mod_en;
    logic [3:0] k_tot;
    logic [3:0] k3;
    logic [3:0] mlog;
    logic [9:0] mask3;
    logic [3:0] mmax;
    logic signed [9:0] ph_hi;
    logic [9:0] c3_ff;
    logic [NCH-1:0] res_vld;
    logic [23:0] res_dat [NCH];
    logic [NCH-1:0] fast_act;
    logic [NCH-1:0] settled;
    logic [15:0] settle_tgt;
    logic [NCH-1:0] pend_ff;
    logic [23:0] pdat_ff [NCH];
    logic [NCH-1:0] grant;
    sdd_word_s push_w;
    logic push_v;
    logic push_rdy;
    logic pop;
    logic fifo_v;
    sdd_word_s fifo_w;
    logic [NCH-1:0] done_ff;
    sdd_conversion_ready_n_e conversion_ready_n_ff;
    logic [3:0] conversion_ready_n_cnt_ff;
    logic conversion_ready_n_n_ff;
    logic a_ok;

    assign hreadyout = hready_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign modulator_clock = modulator_clock_ff;
    assign conversion_ready_n = conversion_ready_n_n_ff;

    // Ratio decode: total, third-order part and first-order part.
    assign k_tot = turbo_ff ? K_TURBO : K_BASE + 4'(osr_sel_ff);
    assign k3 = (k_tot > K3_MAX) ? K3_MAX : k_tot;
    assign mlog = (k_tot > K3_MAX) ? k_tot - K3_MAX : 4'h0;
    assign mask3 = 10'((11'h001 << k3) - 11'h001);
    assign mmax = 4'((5'h01 << mlog) - 5'h01);
    assign ph_hi = $signed(10'((11'h001 << (k3 - 4'h1)) - 11'h001));

    // Settling time in main clocks for the active ratio.
    always_comb begin
        if (mlog == 4'h0) begin
            settle_tgt = 16'(17'h3 << k3) + SETTLE_ADD;
        end else begin
            settle_tgt = 16'((17'(mmax) + 17'h2) << 11) + SETTLE_ADD;
        end
    end

    // Modulator clock divider with one-cycle enable.
    assign mod_en = (div_ff == MOD_DIV - 2'h1);
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            div_ff <= 2'h0;
            modulator_clock_ff <= 1'b0;
        end else begin
            div_ff <= mod_en ? 2'h0 : div_ff + 2'h1;
            modulator_clock_ff <= (div_ff == 2'h0);
        end
    end

    // Reference window counter, cleared on resync.
    always_ff @(posedge ref_clk) begin
        if (!nrst || resync_ff) begin
            c3_ff <= 10'h000;
        end else if (mod_en) begin
            c3_ff <= (c3_ff + 10'h001) & mask3;
        end
    end

    // AHB address phase capture and zero-wait read data.
    assign a_ok = hsel && htrans[1] && hready;
    assign pop = a_ok && !hwrite && (haddr[7:0] == A_DATA) && fifo_v;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ph_ff <= 1'b0;
            addr_ff <= 8'h00;
            hready_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_ph_ff <= a_ok && hwrite;
            addr_ff <= haddr[7:0];
            hready_ff <= 1'b1;
            if (a_ok && !hwrite) begin
                hrdata_ff <= 32'h0000_0000;
                case (haddr[7:0])
                    A_CTRL: begin
                        hrdata_ff[C_OSR+:3] <= osr_sel_ff;
                        hrdata_ff[C_TURBO] <= turbo_ff;
                        hrdata_ff[C_EN+:NCH] <= ch_en_ff;
                    end
                    A_STAT: begin
                        hrdata_ff <= {24'h0, pend_ff, fifo_v, |fast_act,
                            settled};
                    end
                    A_DATA: begin
                        hrdata_ff[D_VLD] <= fifo_v;
                        hrdata_ff[D_CH+:2] <= fifo_v ? fifo_w.ch : 2'h0;
                        hrdata_ff[23:0] <= fifo_v ? fifo_w.data : 24'h0;
                    end
                    A_CFG0: hrdata_ff[CFG_W-1:0] <= cfg_ff[0];
                    A_CFG0 + A_STEP: hrdata_ff[CFG_W-1:0] <= cfg_ff[1];
                    A_CFG0 + 8'h2 * A_STEP: hrdata_ff[CFG_W-1:0] <= cfg_ff[2];
                    default: hrdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register write; resync is a self-clearing pulse.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            osr_sel_ff <= 3'h0;
            turbo_ff <= 1'b0;
            ch_en_ff <= '0;
            resync_ff <= 1'b0;
        end else begin
            resync_ff <= 1'b0;
            if (wr_ph_ff && addr_ff == A_CTRL) begin
                osr_sel_ff <= hwdata[C_OSR+:3];
                turbo_ff <= hwdata[C_TURBO];
                ch_en_ff <= hwdata[C_EN+:NCH];
                resync_ff <= hwdata[C_RESYNC];
            end
        end
    end

    // Per-channel configuration, filters and settling tracking.
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam logic [7:0] A_MY = A_CFG0 + 8'(i) * A_STEP;
        logic en_q_ff;
        logic signed [9:0] ph;
        logic signed [9:0] phc;
        logic e3;
        logic tot_end;
        logic signed [31:0] x;
        logic signed [31:0] i1_ff;
        logic signed [31:0] i2_ff;
        logic signed [31:0] i3_ff;
        logic signed [31:0] z1_ff;
        logic signed [31:0] z2_ff;
        logic signed [31:0] z3_ff;
        logic signed [31:0] d1;
        logic signed [31:0] d2;
        logic signed [31:0] d3;
        logic signed [31:0] s3;
        logic signed [31:0] acc1_ff;
        logic signed [31:0] sum1;
        logic signed [15:0] fa_ff;
        logic signed [31:0] fsum;
        logic signed [31:0] v;
        logic signed [31:0] vs;
        logic [3:0] mcnt_ff;
        logic [1:0] nconv_ff;
        logic [15:0] st_ff;
        logic res_v_ff;
        logic [23:0] res_d_ff;

        // Config write; a mux or gain change restarts settling.
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                cfg_ff[i] <= '0;
                en_q_ff <= 1'b0;
                restart[i] <= 1'b0;
            end else begin
                en_q_ff <= ch_en_ff[i];
                restart[i] <= resync_ff || (ch_en_ff[i] && !en_q_ff);
                if (wr_ph_ff && addr_ff == A_MY) begin
                    cfg_ff[i] <= hwdata[CFG_W-1:0];
                    if (hwdata[CFG_W-1:F_GAIN] != cfg_ff[i][CFG_W-1:F_GAIN])
                    begin
                        restart[i] <= 1'b1;
                    end
                end
            end
        end

        // Phase clip; window ends where the counter meets the phase.
        assign ph = $signed(cfg_ff[i][F_PH+:10]);
        assign phc = (ph > ph_hi) ? ph_hi :
            (ph < -ph_hi - 10'sd1) ? -ph_hi - 10'sd1 : ph;
        assign e3 = mod_en && (((c3_ff - phc) & mask3) == 10'h000);
        assign tot_end = e3 && (mlog == 4'h0 || mcnt_ff == mmax);

        // Third-order comb and normalization to full scale.
        assign x = mod_bits[i] ? 32'sd1 : -32'sd1;
        assign d1 = i3_ff - z1_ff;
        assign d2 = d1 - z2_ff;
        assign d3 = d2 - z3_ff;
        assign s3 = d3 <<< (5'h3 * 5'(K3_MAX - k3));
        assign sum1 = (mcnt_ff == 4'h0 ? 32'sd0 : acc1_ff) + (s3 >>> mlog);
        assign fsum = 32'(fa_ff + 16'(x)) <<< (NORM_MSB - 5'(k_tot));
        assign v = (nconv_ff < FAST_CONVS) ? fsum :
            (mlog == 4'h0) ? s3 : sum1;
        assign vs = v >>> OUT_SHIFT;
        assign fast_act[i] = nconv_ff < FAST_CONVS;

        // Integrators and comb state, cleared on resync.
        always_ff @(posedge ref_clk) begin
            if (!nrst || resync_ff) begin
                i1_ff <= '0;
                i2_ff <= '0;
                i3_ff <= '0;
                z1_ff <= '0;
                z2_ff <= '0;
                z3_ff <= '0;
            end else begin
                if (mod_en) begin
                    i1_ff <= i1_ff + x;
                    i2_ff <= i2_ff + i1_ff;
                    i3_ff <= i3_ff + i2_ff;
                end
                if (e3) begin
                    z1_ff <= i3_ff;
                    z2_ff <= d1;
                    z3_ff <= d2;
                end
            end
        end

        // First-order stages: fast path and post-stage averaging.
        always_ff @(posedge ref_clk) begin
            if (!nrst || resync_ff) begin
                fa_ff <= '0;
                acc1_ff <= '0;
                mcnt_ff <= 4'h0;
            end else begin
                if (mod_en) begin
                    fa_ff <= tot_end ? 16'sd0 : fa_ff + 16'(x);
                end
                if (e3) begin
                    acc1_ff <= sum1;
                    mcnt_ff <= tot_end ? 4'h0 : mcnt_ff + 4'h1;
                end
            end
        end

        // Conversion count selects the path; only reset clears it.
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                nconv_ff <= 2'h0;
            end else if (tot_end && nconv_ff < FAST_CONVS) begin
                nconv_ff <= nconv_ff + 2'h1;
            end
        end

        // Saturated 24-bit result, issued even while settling.
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                res_v_ff <= 1'b0;
                res_d_ff <= 24'h0;
            end else begin
                res_v_ff <= tot_end && ch_en_ff[i];
                if (tot_end) begin
                    res_d_ff <= (vs > 32'sh7fffff) ? SAT_POS :
                        (vs < -32'sh800000) ? SAT_NEG : vs[23:0];
                end
            end
        end
        assign res_vld[i] = res_v_ff;
        assign res_dat[i] = res_d_ff;

        // Settling counter in main clocks.
        always_ff @(posedge ref_clk) begin
            if (!nrst || restart[i]) begin
                st_ff <= 16'h0;
            end else if (st_ff < settle_tgt) begin
                st_ff <= st_ff + 16'h1;
            end
        end
        assign settled[i] = (st_ff >= settle_tgt);
    end

    // Lowest pending channel wins the FIFO slot.
    always_comb begin
        grant = '0;
        push_v = 1'b0;
        push_w = '0;
        for (int c = 0; c < NCH; c++) begin
            if (pend_ff[c] && !push_v) begin
                grant[c] = push_rdy;
                push_v = 1'b1;
                push_w.ch = 2'(c);
                push_w.data = pdat_ff[c];
            end
        end
    end

    // Pending results wait while the FIFO is full; a new one wins.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pend_ff <= '0;
            for (int c = 0; c < NCH; c++) begin
                pdat_ff[c] <= 24'h0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (res_vld[c]) begin
                    pend_ff[c] <= 1'b1;
                    pdat_ff[c] <= res_dat[c];
                end else if (grant[c]) begin
                    pend_ff[c] <= 1'b0;
                end
            end
        end
    end

    sdd_fifo #(.W($bits(sdd_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(push_v),
        .in_data(push_w),
        .in_ready(push_rdy),
        .out_valid(fifo_v),
        .out_data(fifo_w),
        .out_ready(pop)
    );

    // Data ready falls when the last enabled channel window closes.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            done_ff <= '0;
            conversion_ready_n_ff <= CONVERSION_READY_N_IDLE;
            conversion_ready_n_cnt_ff <= 4'h0;
            conversion_ready_n_n_ff <= 1'b1;
        end else begin
            case (conversion_ready_n_ff)
                CONVERSION_READY_N_IDLE: begin
                    done_ff <= done_ff | res_vld;
                    if (ch_en_ff != '0 &&
                        ((done_ff | res_vld) & ch_en_ff) == ch_en_ff) begin
                        done_ff <= '0;
                        conversion_ready_n_ff <= CONVERSION_READY_N_LOW;
                        conversion_ready_n_cnt_ff <= CONVERSION_READY_N_LOW_CYC;
                        conversion_ready_n_n_ff <= 1'b0;
                    end
                end
                CONVERSION_READY_N_LOW: begin
                    done_ff <= done_ff | res_vld;
                    conversion_ready_n_cnt_ff <= conversion_ready_n_cnt_ff - 4'h1;
                    if (conversion_ready_n_cnt_ff == 4'h1) begin
                        conversion_ready_n_ff <= CONVERSION_READY_N_IDLE;
                        conversion_ready_n_n_ff <= 1'b1;
                    end
                end
                default: begin
                    conversion_ready_n_ff <= CONVERSION_READY_N_IDLE;
                    conversion_ready_n_n_ff <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ==== sdd_decim_properties.sv ====
// Concurrent checks on the decimator's pins.
module sdd_decim_properties (
    input wire logic ref_clk, // Main clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write.
    input wire logic hready, // Bus ready.
    input wire logic hreadyout, // Slave ready.
    input wire logic hresp, // Response.
    input wire logic [31:0] hrdata, // Read data.
    input wire logic modulator_clock, // Modulator clock.
    input wire logic conversion_ready_n // Data ready, active low.
);
    import sdd_pkg::*;
    logic rd_ap;
    logic data_dp_ff;
    // A read address phase is taken on this edge.
    assign rd_ap = hsel && htrans[1] && hready && !hwrite;
    // Marks the data phase of a read from the result word.
    always_ff @(posedge ref_clk) begin
        data_dp_ff <= nrst && rd_ap && haddr[7:0] == A_DATA;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_OKAY: assert property (!hresp && hreadyout)
        else $error("bus answer not ready or not okay");
    AST_RESET: assert property (disable iff (1'b0) !nrst |=>
        conversion_ready_n && !modulator_clock && hrdata == 32'h0)
        else $error("outputs not at reset values");
    AST_MODCLK: assert property ($past(nrst, 2) |->
        $changed(modulator_clock))
        else $error("modulator clock missed a toggle");
    AST_CONVERSION_READY_N_LOW: assert property ($fell(conversion_ready_n) |->
        !conversion_ready_n [*4] ##1 conversion_ready_n)
        else $error("data ready low time wrong");
    AST_CONVERSION_READY_N_GAP: assert property ($rose(conversion_ready_n) |->
        conversion_ready_n [*8])
        else $error("data ready fell again too soon");
    AST_HOLD: assert property (!rd_ap |=> $stable(hrdata))
        else $error("read data changed without a read");
    AST_DATA_CH: assert property (data_dp_ff && hrdata[D_VLD] |->
        hrdata[D_CH+1:D_CH] != 2'h3)
        else $error("result word names a missing channel");
    AST_UNMAPPED: assert property (rd_ap && haddr[7:0] > 8'h14 |=>
        hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind sdd_decim sdd_decim_properties u_sdd_decim_properties (.ref_clk,
    .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .modulator_clock, .conversion_ready_n);

// ==== sdd_decim_test.sv ====
// Self-checking bench for the decimator.
module sdd_decim_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sdd_pkg::*;
    logic ref_clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
    logic modulator_clock, conversion_ready_n, rd_dp_ff;
    logic [1:0] htrans;
    logic [2:0] mod_bits, level;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [63:0] notes [$];
    logic [7:0] sel [4] = '{8'h08, 8'h00, 8'h03, 8'h04};
    int nr [4] = '{64, 128, 1024, 2048};
    int fails, n_tests;

    assign hready = hreadyout;
    sdd_decim u_sdd_decim (.ref_clk, .nrst, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .mod_bits, .modulator_clock, .conversion_ready_n);
    sdd_mod_model u_sdd_mod_model (.ref_clk, .modulator_clock, .level,
        .mod_bits);

    // Pseudo-random source for configuration and input level.
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t read %h want %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Waits, bounded, for an edge with the bus ready.
    task automatic waitrdy();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (k >= 64) begin
            fails++;
            conclude();
        end
    endtask

    // One single word transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        waitrdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitrdy();
        rd = hrdata;
    endtask

    // Reads a register and leaves masked expectations for the monitor.
    task automatic rdx(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        notes.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask

    // Monitor pairs each read data phase with the oldest note.
    always @(posedge ref_clk) begin
        if (rd_dp_ff && hreadyout === 1'b1 && notes.size() > 0) begin
            chk(hrdata & notes[0][63:32], notes[0][31:0]);
            void'(notes.pop_front());
        end
        rd_dp_ff <= nrst && hsel && htrans[1] && !hwrite && hreadyout;
    end

    // Free-running main clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        conclude();
    end

    // Main sequence.
    initial begin
        int n;
        nrst = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        level = 3'h0;
        rd_dp_ff = 1'b0;
        seed = 32'd88;
        fails = 0;
        n_tests = 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rdx(A_CTRL, 32'hffff_ffff, 32'h0);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        rdx(8'h20, 32'hffff_ffff, 32'h0);
        rdx(A_DATA, 32'h8000_0000, 32'h0);
        for (int c = 0; c < NCH; c++) begin
            seed = xs(seed);
            bus(1'b1, A_CFG0 + 8'(c) * A_STEP, seed);
            rdx(A_CFG0 + 8'(c) * A_STEP, 32'h7fff, seed & 32'h7fff);
        end
        $display("test 1 done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            level <= {3{seed[0]}};
            bus(1'b1, A_CTRL, {24'h0, sel[(i + 3) % 4]});
            bus(1'b1, A_CTRL, {24'h0, sel[i]});
            bus(1'b1, A_CTRL, {24'h0, sel[i] | 8'h70});
            rdx(A_STAT, 32'hf, i == 0 ? 32'h8 : 32'h0);
            repeat (6 * nr[i] + 200) @(posedge ref_clk);
            rdx(A_STAT, 32'hf, 32'h7);
            n = 0;
            do begin
                bus(1'b0, A_DATA, 32'h0);
                n++;
            end while (rd[D_VLD] === 1'b1 && n < 40);
            chk(32'(n < 40), 32'h1);
            repeat (2 * nr[i] + 20) @(posedge ref_clk);
            for (int w = 0; w < NCH; w++) begin
                rdx(A_DATA, 32'h80ff_ffff,
                    seed[0] ? 32'h807f_ffff : 32'h8080_0000);
            end
            $display("test %0d done", i + 2);
        end
        bus(1'b1, A_CTRL, 32'h0000_0174);
        // Let the resync pulse reach the settling counters first.
        repeat (4) @(posedge ref_clk);
        rdx(A_STAT, 32'h7, 32'h0);
        $display("test 6 done");
        conclude();
    end
endmodule

// ==== sdd_fifo.sv ====
// Result FIFO with valid and ready on both sides.
module sdd_fifo #(
    parameter int W = 26,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk, // System clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic in_valid, // Write request.
    input wire logic [W-1:0] in_data, // Write data.
    output logic in_ready, // Space available.
    output logic out_valid, // Data available.
    output logic [W-1:0] out_data, // Head word.
    input wire logic out_ready // Pop request.
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ff;
    logic [AW:0] rd_ff;
    logic full;
    logic empty;

    // Full when pointers differ only in the wrap bit.
    assign empty = (wr_ff == rd_ff);
    assign full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ff[AW-1:0]];

    // Storage write.
    always_ff @(posedge ref_clk) begin
        if (in_valid && !full) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end
endmodule

// ==== sdd_mod_model.sv ====
// Behavioural modulator feeding one bit per channel.
module sdd_mod_model (
    input wire logic ref_clk, // Main clock.
    input wire logic modulator_clock, // Modulator clock from the block.
    input wire logic [2:0] level, // Bit value wanted per channel.
    output logic [2:0] mod_bits // Bit streams to the block.
);
    logic mclk_ff;
    // New bits appear just after each rise of the modulator clock.
    always @(posedge ref_clk) begin
        mclk_ff <= modulator_clock;
        if (modulator_clock && !mclk_ff) begin
            mod_bits <= level;
        end
    end
    // Start from a known level.
    initial begin
        mod_bits = 3'h0;
        mclk_ff = 1'b0;
    end
endmodule

// ==== sdd_pkg.sv ====
// Shared constants and types for the sigma-delta decimation filter.
package sdd_pkg;
    localparam int NCH = 3;
    localparam int FIFO_DEPTH = 32;
    // Register byte addresses.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_DATA = 8'h08;
    localparam logic [7:0] A_CFG0 = 8'h0c;
    localparam logic [7:0] A_STEP = 8'h04;
    // Control register fields.
    localparam int C_OSR = 0;
    localparam int C_TURBO = 3;
    localparam int C_EN = 4;
    localparam int C_RESYNC = 8;
    // Channel configuration fields.
    localparam int F_PH = 0;
    localparam int F_GAIN = 10;
    localparam int F_MUX = 13;
    localparam int CFG_W = 15;
    // Data register fields.
    localparam int D_VLD = 31;
    localparam int D_CH = 24;
    // Ratio encoding as powers of two.
    localparam logic [3:0] K_TURBO = 4'h6;
    localparam logic [3:0] K_BASE = 4'h7;
    localparam logic [3:0] K3_MAX = 4'ha;
    localparam logic [4:0] NORM_MSB = 5'h1e;
    localparam int OUT_SHIFT = 7;
    // Timing constants.
    localparam int REF_MHZ = 100;
    localparam logic [1:0] MOD_DIV = 2'h2;
    localparam logic [1:0] FAST_CONVS = 2'h2;
    localparam logic [15:0] SETTLE_ADD = 16'h0030;
    localparam int CONVERSION_READY_N_LOW_NS = 40;
    localparam logic [3:0] CONVERSION_READY_N_LOW_CYC = 4'(CONVERSION_READY_N_LOW_NS * REF_MHZ / 1000);
    localparam logic [23:0] SAT_POS = 24'h7fffff;
    localparam logic [23:0] SAT_NEG = 24'h800000;
    typedef struct packed {
        logic [1:0] ch;
        logic [23:0] data;
    } sdd_word_s;
    typedef enum {CONVERSION_READY_N_IDLE, CONVERSION_READY_N_LOW} sdd_conversion_ready_n_e;
endpackage
